// ==== core/actc_clk_div.sv ====
// Module: master clock divider giving the converter clock enable
`timescale 1ns/1ps
module actc_clk_div
  import actc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_sync_n,
  // Enable link
  actc_clk_if.div clk_link
);
  logic [4:0] count;
  logic [4:0] limit;
  // ==========================================
  // Divide ratio select
  // code to ratio
  assign limit = (clk_link.div_sel == 2'b00) ? ACTC_DIV32_M1 :
                 (clk_link.div_sel == 2'b01) ? ACTC_DIV4_M1 :
                 (clk_link.div_sel == 2'b10) ? ACTC_DIV8_M1 :
                 ACTC_DIV2_M1;
  assign clk_link.tick = clk_link.run && (count >= limit);
  // Held at zero while powered down to save toggling
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) count <= 5'h00;
    else if (!clk_link.run || clk_link.tick) count <= 5'h00;
    else count <= count + 5'h01;
  end
  a_tick_ratio: assert property (
    @(posedge clock) disable iff (!rst_sync_n)
    clk_link.tick && clk_link.div_sel == 2'b11 && $stable(clk_link.div_sel)
    |=> !clk_link.tick ##1 (clk_link.tick || !clk_link.run
    || $changed(clk_link.div_sel)))
    else $error("divide by two tick spacing wrong");
endmodule

// ==== core/actc_clk_if.sv ====
// Interface: converter clock enable between top and divider
`timescale 1ns/1ps
interface actc_clk_if;
  logic run;
  logic [1:0] div_sel;
  logic tick;
  modport ctl (output run, output div_sel, input tick);
  modport div (input run, input div_sel, output tick);
endinterface

// ==== core/actc_pkg.sv ====
// Package: register layout and timing constants for ADC timing control
package actc_pkg;
  // ==========================================
  // Register layout
  localparam logic [7:0] ACTC_CTRL_RESET = 8'h40;
  localparam int ACTC_BIT_POWER = 7;
  localparam int ACTC_BIT_EXTREF = 6;
  localparam int ACTC_BIT_DIV_HI = 5;
  localparam int ACTC_BIT_DIV_LO = 4;
  localparam int ACTC_BIT_ACQ_HI = 3;
  localparam int ACTC_BIT_ACQ_LO = 2;
  localparam int ACTC_BIT_TMR_EN = 1;
  localparam int ACTC_BIT_PIN_EN = 0;
  // ==========================================
  // Converter clock dividers, minus one
  localparam logic [4:0] ACTC_DIV32_M1 = 5'h1F;
  localparam logic [4:0] ACTC_DIV4_M1 = 5'h03;
  localparam logic [4:0] ACTC_DIV8_M1 = 5'h07;
  localparam logic [4:0] ACTC_DIV2_M1 = 5'h01;
  // ==========================================
  // Conversion phases in converter clocks
  localparam logic [4:0] ACTC_SYNC_CLKS = 5'h01;
  localparam logic [4:0] ACTC_CONV_CLKS = 5'h0F;
  // Least start-pin low time and its cycle count
  localparam int ACTC_CLOCK_HZ = 10_000_000;
  localparam int ACTC_PIN_MIN_NS = 100;
  localparam int ACTC_PIN_MIN_CYC_I =
    (ACTC_PIN_MIN_NS * (ACTC_CLOCK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0] ACTC_PIN_MIN_CYC =
    4'(ACTC_PIN_MIN_CYC_I < 1 ? 1 : ACTC_PIN_MIN_CYC_I);
  typedef enum logic [1:0] {ACTC_IDLE, ACTC_SYNC, ACTC_ACQ, ACTC_CONV}
    actc_phase_t;
endpackage

// ==== core/actc_top.sv ====
// Module: ADC power, reference, clock and conversion timing control
`timescale 1ns/1ps
// How it works
// - Bit 7 one powers the converter; zero holds it down.
// - Bit 6 one picks external reference; zero the internal one.
// - Divide bits give ratio 32, 4, 8, 2 for codes 00..11.
// - Acquisition bits give 1, 2, 3 or 4 converter clocks.
// - Conversion lasts sync 1 plus acquisition plus 15 clocks.
// - With bit 1 set, timer overflow starts a conversion.
// - With bit 0 set, low start pin starts a conversion.
// - Continuous mode restarts right after each conversion ends.
module actc_top
  import actc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Trigger sources
  input wire logic timer_overflow,
  input wire logic convert_start_n,
  input wire logic software_start,
  input wire logic continuous_mode,
  // Converter core
  output logic converter_power_on,
  output logic external_reference_select,
  output logic conv_clock_tick,
  output logic track_hold_acquire,
  output logic sar_step,
  output logic conversion_busy,
  output logic conversion_done
);
  logic [1:0] rst_pipe;
  logic rst_sync_n;
  logic [7:0] adc_timing_control;
  logic [1:0] pin_sync;
  logic pin_low_prev;
  logic [3:0] pin_low_cnt;
  logic pin_trig;
  logic start_req;
  logic tick;
  actc_phase_t phase;
  actc_phase_t next_phase;
  logic [4:0] phase_cnt;
  logic [4:0] next_phase_cnt;
  logic [4:0] acq_clks;
  logic phase_end;
  logic next_done;
  logic done_r;
  actc_clk_if clk_link ();

  // ==========================================
  // Reset release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) rst_pipe <= 2'b00;
    else rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_sync_n = rst_pipe[1];

  // ==========================================
  // Control register
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) adc_timing_control <= ACTC_CTRL_RESET;
    else if (reg_write) adc_timing_control <= reg_wdata;
  end
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) reg_rdata <= ACTC_CTRL_RESET;
    else reg_rdata <= adc_timing_control;
  end
  assign converter_power_on = adc_timing_control[ACTC_BIT_POWER];
  assign external_reference_select = adc_timing_control[ACTC_BIT_EXTREF];

  // ==========================================
  // Converter clock
  assign clk_link.run = converter_power_on;
  assign clk_link.div_sel = {adc_timing_control[ACTC_BIT_DIV_HI],
                             adc_timing_control[ACTC_BIT_DIV_LO]};
  assign tick = clk_link.tick;
  assign conv_clock_tick = tick;
  actc_clk_div u_div (
    .clock(clock),
    .rst_sync_n(rst_sync_n),
    .clk_link(clk_link)
  );

  // ==========================================
  // Start pin: synchronise, then qualify low width
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) pin_sync <= 2'b11;
    else pin_sync <= {pin_sync[0], convert_start_n};
  end
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) pin_low_cnt <= 4'h0;
    else if (pin_sync[1]) pin_low_cnt <= 4'h0;
    else if (pin_low_cnt < ACTC_PIN_MIN_CYC) pin_low_cnt <= pin_low_cnt + 4'h1;
  end
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) pin_low_prev <= 1'b0;
    else pin_low_prev <= (pin_low_cnt >= ACTC_PIN_MIN_CYC);
  end
  // one start per qualified low pulse
  assign pin_trig = adc_timing_control[ACTC_BIT_PIN_EN] &&
                    (pin_low_cnt >= ACTC_PIN_MIN_CYC) && !pin_low_prev;
  assign start_req = pin_trig || software_start || continuous_mode ||
                     (adc_timing_control[ACTC_BIT_TMR_EN] && timer_overflow);

  // ==========================================
  // Conversion sequencer
  // acquisition length from code
  assign acq_clks = {3'h0, adc_timing_control[ACTC_BIT_ACQ_HI],
                     adc_timing_control[ACTC_BIT_ACQ_LO]} + 5'h01;
  assign phase_end = tick && (phase_cnt == 5'h01);
  always_comb begin
    next_phase = phase;
    next_phase_cnt = phase_cnt;
    next_done = 1'b0;
    unique case (phase)
      ACTC_IDLE: begin
        if (converter_power_on && start_req) begin
          next_phase = ACTC_SYNC;
          next_phase_cnt = ACTC_SYNC_CLKS;
        end
      end
      ACTC_SYNC: begin
        if (phase_end) begin
          next_phase = ACTC_ACQ;
          next_phase_cnt = acq_clks;
        end
      end
      ACTC_ACQ: begin
        if (phase_end) begin
          next_phase = ACTC_CONV;
          next_phase_cnt = ACTC_CONV_CLKS;
        end
      end
      ACTC_CONV: begin
        if (phase_end) begin
          next_phase = ACTC_IDLE;
          next_done = 1'b1;
        end
      end
    endcase
    if (tick && phase != ACTC_IDLE && !phase_end)
      next_phase_cnt = phase_cnt - 5'h01;
    // Powering down aborts any conversion in flight
    if (!converter_power_on) begin
      next_phase = ACTC_IDLE;
      next_done = 1'b0;
    end
  end
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phase <= ACTC_IDLE;
      phase_cnt <= 5'h00;
      done_r <= 1'b0;
    end else begin
      phase <= next_phase;
      phase_cnt <= next_phase_cnt;
      done_r <= next_done;
    end
  end
  assign track_hold_acquire = (phase == ACTC_ACQ);
  assign sar_step = (phase == ACTC_CONV) && tick;
  assign conversion_busy = (phase != ACTC_IDLE);
  assign conversion_done = done_r;

  // ==========================================
  // Checks
  int unsigned tick_count;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) tick_count <= 0;
    else if (phase == ACTC_IDLE) tick_count <= 0;
    else if (tick) tick_count <= tick_count + 1;
  end
  a_conv_length: assert property (
    @(posedge clock) disable iff (!rst_sync_n)
    $rose(conversion_done) |-> tick_count == 16 + int'(acq_clks))
    else $error("conversion length wrong");
  a_power_idle: assert property (
    @(posedge clock) disable iff (!rst_sync_n)
    !converter_power_on |=> !conversion_busy)
    else $error("busy while powered down");
  // Written reference bit must reach the pin on the next cycle
  a_ref_follow: assert property (
    @(posedge clock) disable iff (!rst_sync_n)
    $past(reg_write) |->
      external_reference_select == $past(reg_wdata[ACTC_BIT_EXTREF]))
    else $error("reference select mismatch");
  a_pin_start: assert property (
    @(posedge clock) disable iff (!rst_sync_n)
    pin_trig && converter_power_on && !conversion_busy
    |=> phase == ACTC_SYNC)
    else $error("pin trigger did not start");
  a_timer_start: assert property (
    @(posedge clock) disable iff (!rst_sync_n)
    timer_overflow && adc_timing_control[ACTC_BIT_TMR_EN]
    && converter_power_on && !conversion_busy |=> conversion_busy)
    else $error("timer trigger did not start");
  a_busy_ignore: assert property (
    @(posedge clock) disable iff (!rst_sync_n)
    phase == ACTC_CONV && !phase_end && converter_power_on
    |=> phase == ACTC_CONV)
    else $error("conversion restarted early");
  // Done cycle itself is idle; the restart shows one edge later
  a_cont_restart: assert property (
    @(posedge clock) disable iff (!rst_sync_n)
    conversion_done && continuous_mode && converter_power_on
    |=> phase == ACTC_SYNC)
    else $error("continuous restart missing");
  a_acq_length: assert property (
    @(posedge clock) disable iff (!rst_sync_n)
    $rose(track_hold_acquire) |-> phase_cnt == acq_clks)
    else $error("acquisition length wrong");
  c_one_conv: cover property (@(posedge clock) $rose(conversion_done));
  c_pin_conv: cover property (@(posedge clock) pin_trig ##1 conversion_busy);
  c_cont_conv: cover property (@(posedge clock)
    conversion_done && continuous_mode);
endmodule

// ==== tb/actc_src_model.sv ====
// Far-side model: timer overflow source and start pin driver
`timescale 1ns/1ps
module actc_src_model (
  // Clock
  input wire logic clock,
  // Requests from the bench
  input wire logic tmr_req,
  input wire logic pin_req,
  // Trigger outputs
  output logic timer_overflow,
  output logic convert_start_n
);
  logic [1:0] low_cnt;
  initial begin
    timer_overflow = 1'b0;
    low_cnt = 2'h0;
  end
  always @(posedge clock) timer_overflow <= tmr_req;
  always @(posedge clock) begin
    if (pin_req) low_cnt <= 2'h2;
    else if (low_cnt != 2'h0) low_cnt <= low_cnt - 2'h1;
  end
  assign convert_start_n = (low_cnt == 2'h0);
endmodule

// ==== tb/actc_top_tb.sv ====
// Testbench for ADC conversion timing control
`timescale 1ns/1ps
module actc_top_tb;
  import actc_pkg::*;
  logic clock, rst_n, reg_write, software_start, continuous_mode;
  logic tmr_req, pin_req, timer_overflow, convert_start_n;
  logic power, extref, tick, acquire, step, busy, done;
  logic [7:0] reg_wdata, reg_rdata;
  int miscompares = 0, comparisons = 0, cycles = 0, n, k;
  actc_top dut (.clock(clock), .rst_n(rst_n), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .timer_overflow(timer_overflow), .convert_start_n(convert_start_n),
    .software_start(software_start), .continuous_mode(continuous_mode),
    .converter_power_on(power), .external_reference_select(extref),
    .conv_clock_tick(tick), .track_hold_acquire(acquire),
    .sar_step(step), .conversion_busy(busy), .conversion_done(done));
  actc_src_model src (.clock(clock), .tmr_req(tmr_req),
    .pin_req(pin_req), .timer_overflow(timer_overflow),
    .convert_start_n(convert_start_n));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Tests need about 1300 cycles; fifteen times that means a hang
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      close_out();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] v);
    @(posedge clock) reg_write <= 1'b1;
    reg_wdata <= v;
    @(posedge clock) reg_write <= 1'b0;
    repeat (2) @(negedge clock);
  endtask
  task automatic cnt(input int len, output int nd);
    nd = 0;
    repeat (len) begin
      @(negedge clock);
      if (done === 1'b1) nd++;
    end
  endtask
  task automatic gap(output int g);
    g = 0;
    do begin
      @(negedge clock);
      g++;
    end while (tick !== 1'b1 && done !== 1'b1 && g < 200);
  endtask
  task automatic t_reset();
    check(reg_rdata, 8'h40);
    check({power, extref}, 8'h01);
    n = 0;
    repeat (40) begin
      @(negedge clock);
      if (tick === 1'b1) n++;
    end
    check(8'(n), 8'h00);
    $display("reset test done");
  endtask
  task automatic t_reg();
    wr(8'h80);
    check(reg_rdata, 8'h80);
    check({power, extref}, 8'h02);
    wr(8'h40);
    check({power, extref}, 8'h01);
    $display("register test done");
  endtask
  task automatic t_div();
    int exp [4] = '{32, 4, 8, 2};
    for (int c = 0; c < 4; c++) begin
      wr(8'h80 | 8'(c << 4));
      gap(k);
      gap(k);
      check(8'(k), 8'(exp[c]));
    end
    $display("divider test done");
  endtask
  task automatic t_conv();
    int s, q, b;
    for (int a = 0; a < 4; a++) begin
      wr(8'hB0 | 8'(a << 2));
      // Second cycle of the start lands while busy
      @(posedge clock) software_start <= 1'b1;
      repeat (2) @(posedge clock);
      software_start <= 1'b0;
      s = 0;
      q = 0;
      b = 0;
      k = 0;
      do begin
        @(negedge clock);
        k++;
        if (step === 1'b1) s++;
        if (tick === 1'b1 && acquire === 1'b1) q++;
        if (busy !== 1'b1 && done !== 1'b1) b++;
      end while (done !== 1'b1 && k < 200);
      check(8'(s), 8'(ACTC_CONV_CLKS));
      check(8'(b), 8'h00);
      check(8'(busy), 8'h00);
      check(8'(q), 8'(a + 1));
      cnt(60, n);
      check(8'(n), 8'h00);
    end
    $display("conversion test done");
  endtask
  task automatic t_trig();
    for (int i = 0; i < 4; i++) begin
      wr(8'hB0 | ((i == 1) ? 8'h02 : (i == 3) ? 8'h01 : 8'h00));
      @(posedge clock) tmr_req <= (i < 2);
      pin_req <= (i >= 2);
      @(posedge clock) tmr_req <= 1'b0;
      pin_req <= 1'b0;
      cnt(120, n);
      check(8'(n), 8'(i % 2));
    end
    $display("trigger test done");
  endtask
  task automatic t_cont();
    wr(8'hBC);
    @(posedge clock) continuous_mode <= 1'b1;
    do gap(k); while (done !== 1'b1 && k < 200);
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (done !== 1'b1 && k < 200);
    check(8'(k), 8'h28);
    // Still high at this edge, so one more conversion starts
    @(posedge clock) continuous_mode <= 1'b0;
    cnt(60, n);
    check(8'(n), 8'h01);
    cnt(60, n);
    check(8'(n), 8'h00);
    $display("continuous test done");
  endtask
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    {reg_write, software_start, continuous_mode, tmr_req, pin_req} = 5'h00;
    reg_wdata = 8'h00;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(negedge clock);
    t_reset();
    t_reg();
    t_div();
    t_conv();
    t_trig();
    t_cont();
    close_out();
  end
endmodule
